// ### hw/cbfie_exec.sv
// Overview of operation
// - divide puts quotient, remainder; clears carry, sets excess only on zero divisor
// - count-down subtracts one, branches if nonzero
// - count-down of zero wraps to all ones
// - branch target: advanced pc plus signed displacement
// - port operands start from output latch value
// - count-down accepts direct address or byte register
// - far call pushes pc plus four, high first
// - far call loads 24-bit target from bytes
// - far jump loads 24-bit target, flags untouched
// - far return pops low first, stack down three
// - binary mode needs escape for extended forms
// - source mode needs escape for indirect and register increments
// - byte increment wraps all ones to zero
// - wide increment adds 1/2/4 by short constant, at the width given by size
// - legacy increment decodes four operand forms
// - data pointer increment stays within sixteen bits
// - bit-set branch jumps when bit one, unchanged
// - zero divisor clears carry, sets excess flag
`timescale 1ns/1ps
module cbfie_exec
  import cbfie_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // instruction request
  input wire logic instValid,
  output logic instReady,
  input wire logic escPrefixed,
  input wire logic sourceMode,
  input wire logic [23:0] instAddr,
  input wire logic [7:0] instByte0,
  input wire logic [7:0] instByte1,
  input wire logic [7:0] instByte2,
  input wire logic [7:0] instByte3,
  // operand values
  input wire logic [7:0] accIn,
  input wire logic [7:0] divisorIn,
  input wire logic [7:0] byteOpnd,
  input wire logic opndIsPort,
  input wire logic [7:0] portLatch,
  input wire logic [31:0] wideOpnd,
  input wire logic [15:0] dataPointerIn,
  input wire logic [7:0] stackPointerIn,
  input wire logic testBit,
  // completion
  output logic done,
  output logic unsupported,
  output logic [23:0] pcOut,
  output logic branchTaken,
  // result writes
  output logic accWr,
  output logic [7:0] accData,
  output logic divisorWr,
  output logic [7:0] divisorData,
  output logic byteWr,
  output logic [7:0] byteData,
  output logic [2:0] byteRegSel,
  output logic wideWr,
  output logic [31:0] wideData,
  output logic [1:0] wideSize,
  output logic [3:0] wideIdx,
  output logic dataPointerWr,
  output logic [15:0] dataPointerData,
  output logic stackPointerWr,
  output logic [7:0] stackPointerData,
  output logic flagWr,
  output logic carryFlag,
  output logic arithExcessFlag,
  // stack memory
  output logic stkWr,
  output logic stkRd,
  output logic [7:0] stkAddr,
  output logic [7:0] stkWrData,
  input wire logic [7:0] stkRdData
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic cbfie_op_t decodeOp(input logic [7:0] opc, input logic esc,
                                         input logic srcMode);
    logic extOk;
    logic legOk;
    cbfie_op_t res;
    extOk = srcMode ? !esc : esc;
    legOk = srcMode ? esc : !esc;
    res = OP_NONE;
    if (!esc && opc == OPC_DIV) res = OP_DIV;
    else if (!esc && opc == OPC_COUNT_DOWN_BRANCH_DIR) res = OP_COUNT_DOWN_BRANCH_DIR;
    else if (!esc && opc[7:3] == OPC_COUNT_DOWN_BRANCH_REG) res = OP_COUNT_DOWN_BRANCH_REG;
    else if (extOk && opc == OPC_FAR_CALL) res = OP_CALL;
    else if (extOk && opc == OPC_FAR_JUMP) res = OP_JUMP;
    else if (extOk && opc == OPC_FAR_RET) res = OP_RET;
    else if (extOk && opc == OPC_INC_WIDE) res = OP_INC_WIDE;
    else if (!esc && opc == OPC_INC_ACC) res = OP_INC_ACC;
    else if (!esc && opc == OPC_INC_DIR) res = OP_INC_DIR;
    else if (legOk && opc[7:1] == OPC_INC_IND) res = OP_INC_IND;
    else if (legOk && opc[7:3] == OPC_INC_REG) res = OP_INC_REG;
    else if (!esc && opc == OPC_INC_DP) res = OP_INC_DP;
    else if (!esc && opc == OPC_BIT_SET) res = OP_BIT_SET;
    return res;
  endfunction

  function automatic logic [23:0] relTarget(input logic [23:0] nextPc,
                                            input logic [7:0] rel);
    return nextPc + {{16{rel[7]}}, rel};
  endfunction

  function automatic logic [23:0] opLen(input cbfie_op_t op);
    logic [23:0] len;
    unique case (op)
      OP_COUNT_DOWN_BRANCH_DIR, OP_BIT_SET: len = LEN_THREE;
      OP_COUNT_DOWN_BRANCH_REG, OP_INC_DIR, OP_INC_WIDE: len = LEN_TWO;
      default: len = LEN_ONE;
    endcase
    return len;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    cbfie_state_t state;
    cbfie_op_t op;
    logic [23:0] pcBase;
    logic [7:0] opc;
    logic [7:0] ib1;
    logic [7:0] ib2;
    logic [7:0] ib3;
    logic [7:0] opnd;
    logic [31:0] wide;
    logic [7:0] acc;
    logic [7:0] dvs;
    logic [15:0] data_pointer;
    logic [7:0] sp;
    logic bitVal;
    logic [1:0] cnt;
    logic [23:0] retPc;
    logic divStart;
    logic done;
    logic unsupported;
    logic [23:0] pcOut;
    logic taken;
    logic accWr;
    logic [7:0] accData;
    logic dvsWr;
    logic [7:0] dvsData;
    logic byteWr;
    logic [7:0] byteData;
    logic wideWr;
    logic [31:0] wideData;
    logic [1:0] wideSize;
    logic dpWr;
    logic [15:0] dpData;
    logic spWr;
    logic [7:0] spData;
    logic flagWr;
    logic carry;
    logic excess;
    logic stkWr;
    logic stkRd;
    logic [7:0] stkAddr;
    logic [7:0] stkWrData;
  } cbfie_exec_st_t;

  cbfie_exec_st_t r_ff;
  cbfie_exec_st_t nxt_r;

  cbfie_div_if divBus ();

  cbfie_divider u_divider (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .div(divBus.slave)
  );

  assign divBus.start = r_ff.divStart;
  assign divBus.dividend = r_ff.acc;
  assign divBus.divisor = r_ff.dvs;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] dec;
    logic [7:0] inc;
    logic [23:0] seqPc;
    logic [31:0] step;
    dec = r_ff.opnd - 8'h01;
    inc = r_ff.opnd + 8'h01;
    seqPc = r_ff.pcBase + opLen(r_ff.op);
    step = 32'h0000_0001 << r_ff.ib1[1:0];
    nxt_r = r_ff;
    // one-cycle strobes fall back by default
    nxt_r.divStart = 1'b0;
    nxt_r.done = 1'b0;
    nxt_r.unsupported = 1'b0;
    nxt_r.accWr = 1'b0;
    nxt_r.dvsWr = 1'b0;
    nxt_r.byteWr = 1'b0;
    nxt_r.wideWr = 1'b0;
    nxt_r.dpWr = 1'b0;
    nxt_r.spWr = 1'b0;
    nxt_r.flagWr = 1'b0;
    nxt_r.stkWr = 1'b0;
    nxt_r.stkRd = 1'b0;
    nxt_r.taken = 1'b0;
    unique case (r_ff.state)
      ST_IDLE: begin
        if (instValid) begin
          nxt_r.state = ST_EXEC;
          nxt_r.op = decodeOp(instByte0, escPrefixed, sourceMode);
          nxt_r.pcBase = instAddr;
          nxt_r.opc = instByte0;
          nxt_r.ib1 = instByte1;
          nxt_r.ib2 = instByte2;
          nxt_r.ib3 = instByte3;
          // read-modify-write of a port must not see the pins
          nxt_r.opnd = opndIsPort ? portLatch : byteOpnd;
          nxt_r.wide = wideOpnd;
          nxt_r.acc = accIn;
          nxt_r.dvs = divisorIn;
          nxt_r.data_pointer = dataPointerIn;
          nxt_r.sp = stackPointerIn;
          nxt_r.bitVal = testBit;
          nxt_r.cnt = 2'h0;
        end
      end
      ST_EXEC: begin
        nxt_r.state = ST_IDLE;
        nxt_r.done = 1'b1;
        nxt_r.pcOut = seqPc;
        unique case (r_ff.op)
          OP_DIV: begin
            nxt_r.state = ST_DIV;
            nxt_r.done = 1'b0;
            nxt_r.divStart = 1'b1;
          end
          OP_COUNT_DOWN_BRANCH_DIR, OP_COUNT_DOWN_BRANCH_REG: begin
            nxt_r.byteWr = 1'b1;
            nxt_r.byteData = dec;
            if (dec != 8'h00) begin
              nxt_r.taken = 1'b1;
              nxt_r.pcOut = relTarget(seqPc,
                (r_ff.op == OP_COUNT_DOWN_BRANCH_DIR) ? r_ff.ib2 : r_ff.ib1);
            end
          end
          OP_CALL: begin
            nxt_r.state = ST_PUSH;
            nxt_r.done = 1'b0;
            nxt_r.retPc = r_ff.pcBase + CALL_RET_STEP;
            nxt_r.stkWr = 1'b1;
            nxt_r.stkAddr = r_ff.sp + 8'h01;
            nxt_r.stkWrData = nxt_r.retPc[23:16];
            nxt_r.cnt = 2'h1;
          end
          OP_JUMP: begin
            nxt_r.taken = 1'b1;
            nxt_r.pcOut = {r_ff.ib1, r_ff.ib2, r_ff.ib3};
          end
          OP_RET: begin
            nxt_r.state = ST_POP;
            nxt_r.done = 1'b0;
            nxt_r.stkRd = 1'b1;
            nxt_r.stkAddr = r_ff.sp;
            nxt_r.cnt = 2'h0;
          end
          OP_INC_ACC: begin
            nxt_r.accWr = 1'b1;
            nxt_r.accData = r_ff.acc + 8'h01;
          end
          OP_INC_DIR, OP_INC_IND, OP_INC_REG: begin
            nxt_r.byteWr = 1'b1;
            nxt_r.byteData = inc;
          end
          OP_INC_WIDE: begin
            nxt_r.wideSize = r_ff.ib1[WIDE_SIZE_LSB +: 2];
            nxt_r.wideWr = 1'b1;
            unique case (r_ff.ib1[WIDE_SIZE_LSB +: 2])
              SIZE_BYTE: nxt_r.wideData = {r_ff.wide[31:8], r_ff.wide[7:0] + step[7:0]};
              SIZE_WORD: nxt_r.wideData = {r_ff.wide[31:16], r_ff.wide[15:0] + step[15:0]};
              SIZE_DWORD: nxt_r.wideData = r_ff.wide + step;
              default: begin
                nxt_r.wideWr = 1'b0;
                nxt_r.unsupported = 1'b1;
              end
            endcase
            // the short constant 3 has no encoding
            if (r_ff.ib1[1:0] == 2'h3) begin
              nxt_r.wideWr = 1'b0;
              nxt_r.unsupported = 1'b1;
            end
          end
          OP_INC_DP: begin
            nxt_r.dpWr = 1'b1;
            // extension word is outside this path, so no carry reaches it
            nxt_r.dpData = r_ff.data_pointer + 16'h0001;
          end
          OP_BIT_SET: begin
            if (r_ff.bitVal) begin
              nxt_r.taken = 1'b1;
              nxt_r.pcOut = relTarget(seqPc, r_ff.ib2);
            end
          end
          default: begin
            nxt_r.unsupported = 1'b1;
          end
        endcase
      end
      ST_DIV: begin
        if (divBus.done) begin
          nxt_r.state = ST_IDLE;
          nxt_r.done = 1'b1;
          nxt_r.accWr = 1'b1;
          nxt_r.accData = divBus.quotient;
          nxt_r.dvsWr = 1'b1;
          nxt_r.dvsData = divBus.remainder;
          nxt_r.flagWr = 1'b1;
          nxt_r.carry = 1'b0;
          nxt_r.excess = (r_ff.dvs == 8'h00);
        end
      end
      ST_PUSH: begin
        nxt_r.stkWr = 1'b1;
        nxt_r.cnt = r_ff.cnt + 2'h1;
        if (r_ff.cnt == 2'h1) begin
          nxt_r.stkAddr = r_ff.sp + 8'h02;
          nxt_r.stkWrData = r_ff.retPc[15:8];
        end else begin
          nxt_r.stkAddr = r_ff.sp + STACK_BYTES;
          nxt_r.stkWrData = r_ff.retPc[7:0];
          nxt_r.state = ST_IDLE;
          nxt_r.done = 1'b1;
          nxt_r.spWr = 1'b1;
          nxt_r.spData = r_ff.sp + STACK_BYTES;
          nxt_r.taken = 1'b1;
          nxt_r.pcOut = {r_ff.ib1, r_ff.ib2, r_ff.ib3};
        end
      end
      ST_POP: begin
        // read data lags the strobe by one cycle
        nxt_r.cnt = r_ff.cnt + 2'h1;
        unique case (r_ff.cnt)
          2'h0: begin
            nxt_r.stkRd = 1'b1;
            nxt_r.stkAddr = r_ff.sp - 8'h01;
          end
          2'h1: begin
            nxt_r.retPc[7:0] = stkRdData;
            nxt_r.stkRd = 1'b1;
            nxt_r.stkAddr = r_ff.sp - 8'h02;
          end
          2'h2: begin
            nxt_r.retPc[15:8] = stkRdData;
            nxt_r.state = ST_FIN;
          end
          default: begin
            nxt_r.state = ST_FIN;
          end
        endcase
      end
      ST_FIN: begin
        nxt_r.state = ST_IDLE;
        nxt_r.done = 1'b1;
        nxt_r.taken = 1'b1;
        nxt_r.pcOut = {stkRdData, r_ff.retPc[15:0]};
        nxt_r.spWr = 1'b1;
        nxt_r.spData = r_ff.sp - STACK_BYTES;
      end
      default: begin
        nxt_r.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_ff <= '0;
      r_ff.state <= ST_IDLE;
      r_ff.op <= OP_NONE;
      r_ff.pcOut <= PC_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign instReady = (r_ff.state == ST_IDLE);
  assign done = r_ff.done;
  assign unsupported = r_ff.unsupported;
  assign pcOut = r_ff.pcOut;
  assign branchTaken = r_ff.taken;
  assign accWr = r_ff.accWr;
  assign accData = r_ff.accData;
  assign divisorWr = r_ff.dvsWr;
  assign divisorData = r_ff.dvsData;
  assign byteWr = r_ff.byteWr;
  assign byteData = r_ff.byteData;
  assign byteRegSel = r_ff.opc[REG_SEL_LSB +: 3];
  assign wideWr = r_ff.wideWr;
  assign wideData = r_ff.wideData;
  assign wideSize = r_ff.wideSize;
  assign wideIdx = r_ff.ib1[WIDE_IDX_LSB +: 4];
  assign dataPointerWr = r_ff.dpWr;
  assign dataPointerData = r_ff.dpData;
  assign stackPointerWr = r_ff.spWr;
  assign stackPointerData = r_ff.spData;
  assign flagWr = r_ff.flagWr;
  assign carryFlag = r_ff.carry;
  assign arithExcessFlag = r_ff.excess;
  assign stkWr = r_ff.stkWr;
  assign stkRd = r_ff.stkRd;
  assign stkAddr = r_ff.stkAddr;
  assign stkWrData = r_ff.stkWrData;

endmodule

// ### hw/cbfie_pkg.sv
package cbfie_pkg;

  // ----------------------------------------
  // opcodes (after any escape byte)
  // ----------------------------------------
  localparam logic [7:0] OPC_DIV = 8'h84;
  localparam logic [7:0] OPC_COUNT_DOWN_BRANCH_DIR = 8'hD5;
  localparam logic [4:0] OPC_COUNT_DOWN_BRANCH_REG = 5'h1B;
  localparam logic [7:0] OPC_FAR_CALL = 8'h9A;
  localparam logic [7:0] OPC_FAR_JUMP = 8'h8A;
  localparam logic [7:0] OPC_FAR_RET = 8'hAA;
  localparam logic [7:0] OPC_INC_ACC = 8'h04;
  localparam logic [7:0] OPC_INC_DIR = 8'h05;
  localparam logic [6:0] OPC_INC_IND = 7'h03;
  localparam logic [4:0] OPC_INC_REG = 5'h01;
  localparam logic [7:0] OPC_INC_WIDE = 8'h0B;
  localparam logic [7:0] OPC_INC_DP = 8'hA3;
  localparam logic [7:0] OPC_BIT_SET = 8'h20;
  localparam logic [7:0] ESCAPE_BYTE = 8'hA5;

  // ----------------------------------------
  // field positions and sizes
  // ----------------------------------------
  localparam int REG_SEL_LSB = 0;
  localparam int WIDE_IDX_LSB = 4;
  localparam int WIDE_SIZE_LSB = 2;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h3;
  localparam logic [23:0] CALL_RET_STEP = 24'h000004;
  localparam logic [7:0] STACK_BYTES = 8'h03;

  // ----------------------------------------
  // lengths of the opcode part of each form
  // ----------------------------------------
  localparam logic [23:0] LEN_ONE = 24'h000001;
  localparam logic [23:0] LEN_TWO = 24'h000002;
  localparam logic [23:0] LEN_THREE = 24'h000003;

  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [23:0] PC_RST = 24'h000000;
  localparam logic [3:0] DIV_STEPS = 4'h8;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_DIV = 4'h1,
    OP_COUNT_DOWN_BRANCH_DIR = 4'h2,
    OP_COUNT_DOWN_BRANCH_REG = 4'h3,
    OP_CALL = 4'h4,
    OP_JUMP = 4'h5,
    OP_RET = 4'h6,
    OP_INC_ACC = 4'h7,
    OP_INC_DIR = 4'h8,
    OP_INC_IND = 4'h9,
    OP_INC_REG = 4'hA,
    OP_INC_WIDE = 4'hB,
    OP_INC_DP = 4'hC,
    OP_BIT_SET = 4'hD
  } cbfie_op_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_EXEC = 6'h02,
    ST_DIV = 6'h04,
    ST_PUSH = 6'h08,
    ST_POP = 6'h10,
    ST_FIN = 6'h20
  } cbfie_state_t;

endpackage

// ### hw/cbfie_div_if.sv
`timescale 1ns/1ps
interface cbfie_div_if;
  logic start;
  logic [7:0] dividend;
  logic [7:0] divisor;
  logic done;
  logic [7:0] quotient;
  logic [7:0] remainder;

  modport master (output start, output dividend, output divisor,
                  input done, input quotient, input remainder);
  modport slave (input start, input dividend, input divisor,
                 output done, output quotient, output remainder);
endinterface

// ### hw/cbfie_divider.sv
`timescale 1ns/1ps
module cbfie_divider
  import cbfie_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request and answer
  cbfie_div_if.slave div
);

  typedef struct packed {
    logic busy;
    logic [3:0] cnt;
    logic [7:0] quo;
    logic [8:0] rem;
    logic [7:0] dvs;
    logic done;
  } cbfie_div_st_t;

  cbfie_div_st_t r_ff;
  cbfie_div_st_t nxt_r;

  // ----------------------------------------
  // restoring division, one bit a cycle
  // ----------------------------------------
  // a zero divisor gives quotient all ones; callers treat it as undefined
  always_comb begin
    logic [8:0] trial;
    trial = 9'h000;
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    if (!r_ff.busy) begin
      if (div.start) begin
        nxt_r.busy = 1'b1;
        nxt_r.cnt = DIV_STEPS;
        nxt_r.quo = div.dividend;
        nxt_r.rem = 9'h000;
        nxt_r.dvs = div.divisor;
      end
    end else begin
      trial = {r_ff.rem[7:0], r_ff.quo[7]};
      nxt_r.quo = {r_ff.quo[6:0], 1'b0};
      if (trial >= {1'b0, r_ff.dvs}) begin
        nxt_r.rem = trial - {1'b0, r_ff.dvs};
        nxt_r.quo[0] = 1'b1;
      end else begin
        nxt_r.rem = trial;
      end
      nxt_r.cnt = r_ff.cnt - 4'h1;
      if (r_ff.cnt == 4'h1) begin
        nxt_r.busy = 1'b0;
        nxt_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign div.done = r_ff.done;
  assign div.quotient = r_ff.quo;
  assign div.remainder = r_ff.rem[7:0];

endmodule

// ### dv/cbfie_exec_chk.sv
`timescale 1ns/1ps
module cbfie_exec_chk
  import cbfie_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // sampled operands
  input wire logic [7:0] divisorIn,
  input wire logic [15:0] dataPointerIn,
  // completion
  input wire logic done,
  input wire logic unsupported,
  input wire logic branchTaken,
  // result writes
  input wire logic accWr,
  input wire logic divisorWr,
  input wire logic byteWr,
  input wire logic [7:0] byteData,
  input wire logic wideWr,
  input wire logic [1:0] wideSize,
  input wire logic dataPointerWr,
  input wire logic [15:0] dataPointerData,
  input wire logic stackPointerWr,
  input wire logic [7:0] stackPointerData,
  input wire logic flagWr,
  input wire logic carryFlag,
  input wire logic arithExcessFlag,
  // stack memory
  input wire logic stkWr,
  input wire logic stkRd,
  input wire logic [7:0] stkAddr
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence push_s;
    stkWr ##1 (stkWr && stkAddr == $past(stkAddr) + 8'h01)
    ##1 (stkWr && stkAddr == $past(stkAddr) + 8'h01 && done && stackPointerData == stkAddr);
  endsequence
  sequence pop_s;
    stkRd ##1 (stkRd && stkAddr == $past(stkAddr) - 8'h01)
    ##3 (done && stackPointerWr && stackPointerData == $past(stkAddr, 4) - 8'h03);
  endsequence

  call_push_a: assert property ($rose(stkWr) |-> push_s)
    else $error("far call push order wrong");
  ret_pop_a: assert property ($rose(stkRd) |-> pop_s)
    else $error("far return pop order wrong");
  div_zero_a: assert property (flagWr |-> !carryFlag
    && arithExcessFlag == ($past(divisorIn, 12) == 8'h00)) else $error("divide flags wrong");
  div_pair_a: assert property (divisorWr |-> accWr && flagWr && done && !carryFlag)
    else $error("divide writes not paired");
  dp_inc_a: assert property (dataPointerWr |-> done
    && dataPointerData == $past(dataPointerIn, 2) + 16'h0001) else $error("pointer sum wrong");
  unsup_quiet_a: assert property (unsupported |-> done && !(accWr || byteWr
    || wideWr || stkWr || dataPointerWr || stackPointerWr)) else $error("refused op wrote");
  count_down_branch_taken_a: assert property (branchTaken && byteWr |-> byteData != 8'h00)
    else $error("branch taken on zero count");
  wide_size_a: assert property (wideWr |-> done && wideSize != 2'h2)
    else $error("wide size code illegal");
endmodule

bind cbfie_exec cbfie_exec_chk chk (.*);

// ### dv/cbfie_exec_tb_top.sv
`timescale 1ns/1ps
module cbfie_exec_tb_top
  import cbfie_pkg::*;
;
  logic ref_clk = 1'b0, rst_n = 1'b0, instValid = 1'b0, escPrefixed = 1'b0;
  logic sourceMode = 1'b0, opndIsPort = 1'b0, testBit = 1'b0, sawFlag;
  logic [23:0] instAddr = 24'h001000;
  logic [7:0] instByte0 = 8'h00, instByte1 = 8'h00, instByte2 = 8'h00, instByte3 = 8'h00;
  logic [7:0] accIn = 8'h00, divisorIn = 8'h00, byteOpnd = 8'h00, portLatch = 8'h00;
  logic [7:0] stackPointerIn = 8'h00, stkRdData = 8'h5A;
  logic [31:0] wideOpnd = 32'h0;
  logic [15:0] dataPointerIn = 16'h0;
  logic instReady, done, unsupported, branchTaken, accWr, divisorWr, byteWr, wideWr;
  logic dataPointerWr, stackPointerWr, flagWr, carryFlag, arithExcessFlag, stkWr, stkRd;
  logic [23:0] pcOut;
  logic [7:0] accData, divisorData, byteData, stackPointerData, stkAddr, stkWrData;
  logic [2:0] byteRegSel;
  logic [31:0] wideData;
  logic [1:0] wideSize;
  logic [3:0] wideIdx;
  logic [15:0] dataPointerData;
  logic [7:0] stkMem [256];
  logic [7:0] pushA [$];
  logic [7:0] pushD [$];
  int n_mismatch = 0;
  int checks = 0;

  cbfie_exec dut (.*);

  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------
  // stack memory, one cycle read latency
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (stkWr) stkMem[stkAddr] <= stkWrData;
    // stale data is inverted so a late read never matches by luck
    stkRdData <= stkRd ? stkMem[stkAddr] : ~stkRdData;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic go(input logic [7:0] c0, c1, c2, c3, input logic esc);
    int n;
    @(posedge ref_clk);
    instValid <= 1'b1;
    instByte0 <= c0;
    instByte1 <= c1;
    instByte2 <= c2;
    instByte3 <= c3;
    escPrefixed <= esc;
    @(posedge ref_clk);
    instValid <= 1'b0;
    sawFlag = 1'b0;
    pushA.delete();
    pushD.delete();
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      #1;
      if (stkWr === 1'b1) begin
        pushA.push_back(stkAddr);
        pushD.push_back(stkWrData);
      end
      if (flagWr === 1'b1) sawFlag = 1'b1;
      if (done === 1'b1) break;
    end
    if (n == 40) chk(64'h0, 64'h1);
  endtask

  task automatic t_div();
    accIn <= 8'hFB;
    divisorIn <= 8'h12;
    go(8'h84, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({accWr, divisorWr, accData, divisorData, carryFlag, arithExcessFlag}, 20'hC3444);
    chk({instReady, done}, 2'b11);
    divisorIn <= 8'h00;
    go(8'h84, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({flagWr, carryFlag, arithExcessFlag}, 3'b101);
  endtask

  task automatic t_count_down_branch();
    byteOpnd <= 8'h01;
    go(8'hDB, 8'hF0, 8'h00, 8'h00, 1'b0);
    chk({byteWr, byteData, branchTaken, byteRegSel}, {1'b1, 8'h00, 1'b0, 3'h3});
    chk(pcOut, 24'h001002);
    byteOpnd <= 8'h00;
    go(8'hDB, 8'hF0, 8'h00, 8'h00, 1'b0);
    chk({byteData, branchTaken}, {8'hFF, 1'b1});
    chk(pcOut, 24'h000FF2);
    sourceMode <= 1'b1;
    opndIsPort <= 1'b1;
    portLatch <= 8'h70;
    go(8'hD5, 8'h40, 8'h05, 8'h00, 1'b0);
    chk({byteData, branchTaken}, {8'h6F, 1'b1});
    chk(pcOut, 24'h001008);
    opndIsPort <= 1'b0;
  endtask

  task automatic t_call_ret();
    sourceMode <= 1'b1;
    instAddr <= 24'h054321;
    stackPointerIn <= 8'h07;
    go(8'h9A, 8'h12, 8'h34, 8'h56, 1'b0);
    chk({pushA[0], pushD[0], pushA[1], pushD[1], pushA[2], pushD[2]}, 48'h0805_0943_0A25);
    chk({pcOut, stackPointerData, branchTaken}, {24'h123456, 8'h0A, 1'b1});
    stackPointerIn <= 8'h0A;
    go(8'hAA, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({pcOut, stackPointerData, branchTaken}, {24'h054325, 8'h07, 1'b1});
    sourceMode <= 1'b0;
    go(8'h9A, 8'h12, 8'h34, 8'h56, 1'b0);
    chk({unsupported, 8'(pushA.size())}, {1'b1, 8'h00});
    instAddr <= 24'h001000;
  endtask

  task automatic t_jump();
    sourceMode <= 1'b0;
    go(8'h8A, 8'hAB, 8'hCD, 8'hEF, 1'b1);
    chk({pcOut, branchTaken, sawFlag, unsupported}, {24'hABCDEF, 3'b100});
  endtask

  task automatic t_inc();
    logic [7:0] forms [4] = '{8'h04, 8'h05, 8'h06, 8'h0A};
    sourceMode <= 1'b0;
    accIn <= 8'hFF;
    byteOpnd <= 8'hFF;
    for (int i = 0; i < 4; i++) begin
      go(forms[i], 8'h30, 8'h00, 8'h00, 1'b0);
      chk({accWr | byteWr, accWr ? accData : byteData}, {1'b1, 8'h00});
      chk(pcOut, (i == 1) ? 24'h001002 : 24'h001001);
    end
    sourceMode <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      go(forms[2 + j / 2], 8'h30, 8'h00, 8'h00, j[0]);
      chk(unsupported, !j[0]);
    end
    sourceMode <= 1'b0;
    opndIsPort <= 1'b1;
    portLatch <= 8'h3F;
    byteOpnd <= 8'h00;
    go(8'h05, 8'h30, 8'h00, 8'h00, 1'b0);
    chk({byteWr, byteData}, {1'b1, 8'h40});
    opndIsPort <= 1'b0;
  endtask

  task automatic t_wide();
    logic [1:0] sz [3] = '{SIZE_BYTE, SIZE_WORD, SIZE_DWORD};
    logic [31:0] mask;
    sourceMode <= 1'b1;
    wideOpnd <= 32'h000000FE;
    for (int s = 0; s < 3; s++) begin
      mask = (s == 0) ? 32'hFF : (s == 1) ? 32'hFFFF : 32'hFFFFFFFF;
      for (int v = 0; v < 3; v++) begin
        go(8'h0B, {4'h5, sz[s], 2'(v)}, 8'h00, 8'h00, 1'b0);
        chk({wideWr, wideSize, wideIdx, wideData},
          {1'b1, sz[s], 4'h5, (32'hFE + (32'h1 << v)) & mask});
      end
    end
    sourceMode <= 1'b0;
    go(8'h0B, 8'h50, 8'h00, 8'h00, 1'b0);
    // unprefixed in binary mode this is the byte register increment
    chk({unsupported, wideWr, byteWr, byteData}, {3'b001, 8'h01});
  endtask

  task automatic t_dp();
    dataPointerIn <= 16'h12FF;
    go(8'hA3, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({dataPointerWr, dataPointerData}, {1'b1, 16'h1300});
    dataPointerIn <= 16'hFFFF;
    go(8'hA3, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({dataPointerWr, dataPointerData}, {1'b1, 16'h0000});
  endtask

  task automatic t_bit();
    testBit <= 1'b1;
    go(8'h20, 8'h33, 8'hFC, 8'h00, 1'b0);
    chk({pcOut, branchTaken, byteWr}, {24'h000FFF, 2'b10});
    testBit <= 1'b0;
    go(8'h20, 8'h33, 8'hFC, 8'h00, 1'b0);
    chk({pcOut, branchTaken, byteWr}, {24'h001003, 2'b00});
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_div();
    t_count_down_branch();
    t_call_ret();
    t_jump();
    t_inc();
    t_wide();
    t_dp();
    t_bit();
    conclude();
  end

  // ----------------------------------------
  // watchdog, far beyond the longest run
  // ----------------------------------------
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule
